// ==== hw/timer_control_slave.sv ====
// counter control, master trigger output and slave controller of a timer
// assumes the link peer runs on sys_clk_in; software follows the mode
// restrictions below, the block does not police them
`timescale 1ns/1ns
`default_nettype none
module timer_control_slave
  import timer_ctl_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  input  wire logic [7:0]        addr_in,
  input  wire logic [REG_W-1:0]  wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [REG_W-1:0]  rdata_out,
  timer_link_if.timer            link,
  input  wire logic [3:0]        compare_ref_in,
  input  wire logic              channel_one_match_in,
  input  wire logic [CTRL_W-1:0] channel_ctrl_in,
  output logic      [CTRL_W-1:0] channel_ctrl_out,
  output logic      [CNT_W-1:0]  counter_out,
  output logic                   update_event_out,
  output logic                   update_irq_out,
  output logic                   compare_allow_out,
  output logic                   counter_running_out
);
  import timer_ctl_pkg::*;
  logic [7:0]       ctl_one_r, ctl_two_r, slv_ctl_r;
  logic             dir_r, cnt_enable_r, update_flag_r;
  logic [CNT_W-1:0] reload_pre_r, reload_act_r, cnt_nxt;
  logic             dir_nxt, ovf, upd_evt, flag_set;
  logic             in_one_d_r, in_two_d_r, trg_now_d_r, trg_cnt_d_r;
  logic             trg_now, trg_cnt, trg_out, trg_rise;
  logic             edge_one, edge_two, enc_pulse, enc_up, go_up, tick;
  logic             sw_upd, sw_com, slave_rst, slave_start, allow;
  logic             ch1_evt, apply_ctrl, hw_dir, center, encoder;
  logic             gated_on;
  align_e           align;
  slave_e           smode;
  master_e          mmode;
  trig_src_e        tsel;
  logic [7:0]       ctl_one_rd;

  // ==========================================================
  // register port decode
  function automatic logic hit(input logic s, input logic [7:0] a,
                               input logic [7:0] want);
    return s && (a == want);
  endfunction

  // trigger input multiplexer; reserved codes give a quiet low
  function automatic logic pick(input trig_src_e s, input logic z,
                                input logic t, input logic ed,
                                input logic a, input logic b,
                                input logic e);
    case (s)
      TRG_INT_ZERO:  return z;
      TRG_INT_THREE: return t;
      TRG_EDGE_ONE:  return ed;
      TRG_IN_ONE:    return a;
      TRG_IN_TWO:    return b;
      TRG_EXT:       return e;
      default:       return 1'b0;
    endcase
  endfunction

  assign align   = align_e'(ctl_one_r[ALIGN_LSB +: 2]);
  assign smode   = slave_e'(slv_ctl_r[SLAVE_LSB +: 3]);
  assign mmode   = master_e'(ctl_two_r[MASTER_LSB +: 3]);
  assign tsel    = trig_src_e'(slv_ctl_r[TSRC_LSB +: 3]);
  assign center  = (align != ALIGN_EDGE);
  // encoder assumed never combined with center modes
  assign encoder = (smode == SLV_ENC_ONE) || (smode == SLV_ENC_TWO) ||
                   (smode == SLV_ENC_BOTH);
  assign hw_dir  = center | encoder;
  assign sw_upd  = hit(wr_in, addr_in, ADDR_EVGEN) & wdata_in[EV_UPD_BIT];
  assign sw_com  = hit(wr_in, addr_in, ADDR_EVGEN) & wdata_in[EV_COM_BIT];

  // ==========================================================
  // trigger path; source assumed stable while in use
  assign edge_one = link.filtered_input_one ^ in_one_d_r;
  assign edge_two = link.filtered_input_two ^ in_two_d_r;
  assign trg_now  = pick(tsel, link.internal_trigger_zero,
                         link.internal_trigger_three, edge_one,
                         link.filtered_input_one, link.filtered_input_two,
                         link.filtered_external_trigger);
  // sync delays own effect, trigger output sees it undelayed
  assign trg_cnt  = slv_ctl_r[SYNC_BIT] ? trg_now_d_r : trg_now;
  assign trg_out  = slv_ctl_r[SYNC_BIT] ? trg_now : trg_now_d_r;
  assign trg_rise = trg_cnt & ~trg_cnt_d_r;
  assign slave_rst   = trg_rise && (smode == SLV_RESET);
  assign slave_start = trg_rise && (smode == SLV_TRIGGER);
  assign gated_on    = (smode == SLV_GATED) && trg_cnt;

  // encoder: direction from the level of the opposite input
  assign enc_up    = edge_two ? ~(link.filtered_input_two ^
                                  link.filtered_input_one)
                              : (link.filtered_input_one ^
                                 link.filtered_input_two);
  assign enc_pulse = ((smode == SLV_ENC_ONE) && edge_two) ||
                     ((smode == SLV_ENC_TWO) && edge_one) ||
                     ((smode == SLV_ENC_BOTH) && (edge_one | edge_two));

  // count tick per slave mode; every mode needs the enable bit
  always_comb begin
    case (smode)
      SLV_OFF:       tick = cnt_enable_r;
      SLV_GATED:     tick = cnt_enable_r & trg_cnt;
      SLV_EXT_CLOCK: tick = cnt_enable_r & trg_rise;
      SLV_ENC_ONE,
      SLV_ENC_TWO,
      SLV_ENC_BOTH:  tick = cnt_enable_r & enc_pulse;
      default:       tick = cnt_enable_r;
    endcase
  end

  // ==========================================================
  // counter next state
  assign go_up = encoder ? enc_up : ~dir_r;
  always_comb begin
    cnt_nxt = counter_out;
    dir_nxt = dir_r;
    ovf     = 1'b0;
    if (encoder && (edge_one || edge_two)) begin
      dir_nxt = ~enc_up;
    end
    if (sw_upd || slave_rst) begin
      // reinit even with updates disabled
      cnt_nxt = (dir_r && !center) ? reload_act_r : CNT_ZERO;
      if (center) begin
        dir_nxt = 1'b0;
      end
    end else if (tick) begin
      if (go_up) begin
        if (counter_out >= reload_act_r) begin
          ovf = 1'b1;
          if (center) begin
            dir_nxt = 1'b1; // turn at the top
            cnt_nxt = reload_act_r - CNT_ONE;
          end else begin
            cnt_nxt = CNT_ZERO;
          end
        end else begin
          cnt_nxt = counter_out + CNT_ONE;
        end
      end else begin
        if (counter_out == CNT_ZERO) begin
          ovf = 1'b1;
          if (center) begin
            dir_nxt = 1'b0; // turn at the bottom
            cnt_nxt = CNT_ONE;
          end else begin
            cnt_nxt = reload_act_r;
          end
        end else begin
          cnt_nxt = counter_out - CNT_ONE;
        end
      end
    end
  end

  // update event and flag qualification
  assign upd_evt  = ~ctl_one_r[UPDATE_DISABLE_BIT] & (ovf | sw_upd | slave_rst);
  assign flag_set = upd_evt & (ovf | ~ctl_one_r[USRC_BIT]);

  // compare flag window per alignment
  always_comb begin
    case (align)
      ALIGN_CENTER_DN: allow = dir_r;
      ALIGN_CENTER_UP: allow = ~dir_r;
      default:         allow = 1'b1;
    endcase
  end
  assign ch1_evt    = channel_one_match_in & allow;
  assign apply_ctrl = sw_com | (ctl_two_r[COMSRC_BIT] & trg_rise);

  // ==========================================================
  // control registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_one_r <= CTL_ONE_RST;
      ctl_two_r <= CTL_TWO_RST;
      slv_ctl_r <= SLV_CTL_RST;
    end else if (ce_in) begin
      if (hit(wr_in, addr_in, ADDR_CTL_ONE)) begin
        ctl_one_r <= wdata_in & CTL_ONE_MASK;
      end
      if (hit(wr_in, addr_in, ADDR_CTL_TWO)) begin
        ctl_two_r <= wdata_in & CTL_TWO_MASK;
      end
      if (hit(wr_in, addr_in, ADDR_SLV_CTL)) begin
        slv_ctl_r <= wdata_in & SLV_CTL_MASK;
      end
    end
  end

  // enable bit: hardware stop and start win over a software write
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_enable_r <= 1'b0;
    end else if (ce_in) begin
      if (upd_evt && ctl_one_r[PULSE_BIT]) begin
        cnt_enable_r <= 1'b0;
      end else if (slave_start) begin
        cnt_enable_r <= 1'b1;
      end else if (hit(wr_in, addr_in, ADDR_CTL_ONE)) begin
        cnt_enable_r <= wdata_in[ENABLE_BIT];
      end
    end
  end

  // counter and direction; software direction ignored when hw owns it
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      counter_out <= CNT_ZERO;
      dir_r       <= 1'b0;
    end else if (ce_in) begin
      counter_out <= cnt_nxt;
      if (hit(wr_in, addr_in, ADDR_CTL_ONE) && !hw_dir) begin
        dir_r <= wdata_in[DIR_BIT];
      end else begin
        dir_r <= dir_nxt;
      end
    end
  end

  // reload value: direct write or preload copy
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reload_pre_r <= RELOAD_RST;
      reload_act_r <= RELOAD_RST;
    end else if (ce_in) begin
      if (upd_evt && ctl_one_r[RELOAD_PRE_BIT]) begin
        reload_act_r <= reload_pre_r; // shadow load on update
      end
      if (hit(wr_in, addr_in, ADDR_RLD_HI)) begin
        reload_pre_r[15:8] <= wdata_in;
        if (!ctl_one_r[RELOAD_PRE_BIT]) begin
          reload_act_r[15:8] <= wdata_in;
        end
      end
      if (hit(wr_in, addr_in, ADDR_RLD_LO)) begin
        reload_pre_r[7:0] <= wdata_in;
        if (!ctl_one_r[RELOAD_PRE_BIT]) begin
          reload_act_r[7:0] <= wdata_in;
        end
      end
    end
  end

  // update flag: a set in the clearing cycle wins
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      update_flag_r <= 1'b0;
    end else if (ce_in) begin
      if (flag_set) begin
        update_flag_r <= 1'b1;
      end else if (hit(wr_in, addr_in, ADDR_STATUS) &&
                   !wdata_in[ST_UPD_BIT]) begin
        update_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // edge history and outputs
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_one_d_r          <= 1'b0;
      in_two_d_r          <= 1'b0;
      trg_now_d_r         <= 1'b0;
      trg_cnt_d_r         <= 1'b0;
      update_event_out    <= 1'b0;
      update_irq_out      <= 1'b0;
      compare_allow_out   <= 1'b1;
      counter_running_out <= 1'b0;
    end else if (ce_in) begin
      in_one_d_r          <= link.filtered_input_one;
      in_two_d_r          <= link.filtered_input_two;
      trg_now_d_r         <= trg_now;
      trg_cnt_d_r         <= trg_cnt;
      update_event_out    <= upd_evt;
      update_irq_out      <= flag_set;
      compare_allow_out   <= allow;
      counter_running_out <= cnt_enable_r | gated_on;
    end
  end

  // channel control bits: immediate or held until apply
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      channel_ctrl_out <= BYTE_ZERO;
    end else if (ce_in) begin
      if (!ctl_two_r[CPRE_BIT] || apply_ctrl) begin
        channel_ctrl_out <= channel_ctrl_in;
      end
    end
  end

  // trigger output, registered so peers see a clean level
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.trigger_output <= 1'b0;
    end else if (ce_in) begin
      case (mmode)
        MST_RESET:  link.trigger_output <= sw_upd | slave_rst;
        MST_ENABLE: link.trigger_output <= cnt_enable_r |
            ((smode == SLV_GATED) & trg_out);
        MST_UPDATE: link.trigger_output <= upd_evt;
        MST_MATCH:  link.trigger_output <= ch1_evt;
        MST_REF1:   link.trigger_output <= compare_ref_in[0];
        MST_REF2:   link.trigger_output <= compare_ref_in[1];
        MST_REF3:   link.trigger_output <= compare_ref_in[2];
        MST_REF4:   link.trigger_output <= compare_ref_in[3];
        default:    link.trigger_output <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // read port: data only in the cycle after the strobe
  always_comb begin
    ctl_one_rd             = ctl_one_r;
    ctl_one_rd[DIR_BIT]    = dir_r;
    ctl_one_rd[ENABLE_BIT] = cnt_enable_r;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= BYTE_ZERO;
    end else if (ce_in) begin
      rdata_out <= BYTE_ZERO;
      if (rd_in) begin
        case (addr_in)
          ADDR_CTL_ONE: rdata_out <= ctl_one_rd;
          ADDR_CTL_TWO: rdata_out <= ctl_two_r;
          ADDR_SLV_CTL: rdata_out <= slv_ctl_r;
          ADDR_RLD_HI:  rdata_out <= reload_act_r[15:8];
          ADDR_RLD_LO:  rdata_out <= reload_act_r[7:0];
          ADDR_CNT_HI:  rdata_out <= counter_out[15:8];
          ADDR_CNT_LO:  rdata_out <= counter_out[7:0];
          ADDR_STATUS:  rdata_out <= {7'h00, update_flag_r};
          default:      rdata_out <= BYTE_ZERO;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/timer_ctl_pkg.sv ====
// constants, field positions and mode codes of the timer control block
// assumes an 8-bit register port and a 16-bit counter
package timer_ctl_pkg;
  // ==========================================================
  // widths and register offsets
  localparam int          CNT_W          = 16;
  localparam int          REG_W          = 8;
  localparam int          CTRL_W         = 8;
  localparam logic [7:0]  ADDR_CTL_ONE   = 8'h00;
  localparam logic [7:0]  ADDR_CTL_TWO   = 8'h01;
  localparam logic [7:0]  ADDR_SLV_CTL   = 8'h02;
  localparam logic [7:0]  ADDR_RLD_HI    = 8'h10;
  localparam logic [7:0]  ADDR_RLD_LO    = 8'h11;
  localparam logic [7:0]  ADDR_CNT_HI    = 8'h12;
  localparam logic [7:0]  ADDR_CNT_LO    = 8'h13;
  localparam logic [7:0]  ADDR_EVGEN     = 8'h14;
  localparam logic [7:0]  ADDR_STATUS    = 8'h15;
  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0]  CTL_ONE_RST    = 8'h00;
  localparam logic [7:0]  CTL_TWO_RST    = 8'h00;
  localparam logic [7:0]  SLV_CTL_RST    = 8'h00;
  localparam logic [7:0]  CTL_ONE_MASK   = 8'hee;
  localparam logic [7:0]  CTL_TWO_MASK   = 8'h75;
  localparam logic [7:0]  SLV_CTL_MASK   = 8'hf7;
  localparam logic [15:0] RELOAD_RST     = 16'hffff;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CNT_ONE        = 16'h0001;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  // ==========================================================
  // field positions
  localparam int          RELOAD_PRE_BIT = 7;
  localparam int          ALIGN_LSB      = 5;
  localparam int          DIR_BIT        = 4;
  localparam int          PULSE_BIT      = 3;
  localparam int          USRC_BIT       = 2;
  localparam int          UPDATE_DISABLE_BIT       = 1;
  localparam int          ENABLE_BIT     = 0;
  localparam int          MASTER_LSB     = 4;
  localparam int          COMSRC_BIT     = 2;
  localparam int          CPRE_BIT       = 0;
  localparam int          SYNC_BIT       = 7;
  localparam int          TSRC_LSB       = 4;
  localparam int          SLAVE_LSB      = 0;
  localparam int          EV_UPD_BIT     = 0;
  localparam int          EV_COM_BIT     = 5;
  localparam int          ST_UPD_BIT     = 0;
  // ==========================================================
  // mode codes
  typedef enum logic [1:0] {
    ALIGN_EDGE        = 2'b00,
    ALIGN_CENTER_DN   = 2'b01,
    ALIGN_CENTER_UP   = 2'b10,
    ALIGN_CENTER_BOTH = 2'b11
  } align_e;
  typedef enum logic [2:0] {
    SLV_OFF       = 3'b000,
    SLV_ENC_ONE   = 3'b001,
    SLV_ENC_TWO   = 3'b010,
    SLV_ENC_BOTH  = 3'b011,
    SLV_RESET     = 3'b100,
    SLV_GATED     = 3'b101,
    SLV_TRIGGER   = 3'b110,
    SLV_EXT_CLOCK = 3'b111
  } slave_e;
  typedef enum logic [2:0] {
    MST_RESET  = 3'b000,
    MST_ENABLE = 3'b001,
    MST_UPDATE = 3'b010,
    MST_MATCH  = 3'b011,
    MST_REF1   = 3'b100,
    MST_REF2   = 3'b101,
    MST_REF3   = 3'b110,
    MST_REF4   = 3'b111
  } master_e;
  typedef enum logic [2:0] {
    TRG_INT_ZERO  = 3'b000,
    TRG_RSV_ONE   = 3'b001,
    TRG_RSV_TWO   = 3'b010,
    TRG_INT_THREE = 3'b011,
    TRG_EDGE_ONE  = 3'b100,
    TRG_IN_ONE    = 3'b101,
    TRG_IN_TWO    = 3'b110,
    TRG_EXT       = 3'b111
  } trig_src_e;
endpackage

// ==== hw/timer_link_if.sv ====
// trigger wires between the timer and its peers (other timers, adc)
// assumes both ends run on the same system clock
`timescale 1ns/1ns
`default_nettype none
interface timer_link_if;
  logic trigger_output;
  logic filtered_input_one;
  logic filtered_input_two;
  logic filtered_external_trigger;
  logic internal_trigger_zero;
  logic internal_trigger_three;
  // ==========================================================
  // one modport per end
  modport timer (
    output trigger_output,
    input  filtered_input_one,
    input  filtered_input_two,
    input  filtered_external_trigger,
    input  internal_trigger_zero,
    input  internal_trigger_three
  );
  modport peer (
    input  trigger_output,
    output filtered_input_one,
    output filtered_input_two,
    output filtered_external_trigger,
    output internal_trigger_zero,
    output internal_trigger_three
  );
endinterface
`default_nettype wire

// ==== hw/trigger_peer.sv ====
// far end of the trigger link: drives trigger lines, watches the output
// assumes raw inputs come from pins and need synchronising
`timescale 1ns/1ns
`default_nettype none
module trigger_peer
  import timer_ctl_pkg::*;
(
  input  wire logic  sys_clk_in,
  input  wire logic  rst_n_in,
  input  wire logic  ce_in,
  input  wire logic  input_one_in,
  input  wire logic  input_two_in,
  input  wire logic  ext_trig_in,
  input  wire logic  int_zero_in,
  input  wire logic  int_three_in,
  timer_link_if.peer link,
  output logic       trig_level_out,
  output logic       trig_rise_out
);
  import timer_ctl_pkg::*;
  localparam int NLINES = 5;
  logic [NLINES-1:0] raw;
  logic [NLINES-1:0] sync_a_r;
  logic [NLINES-1:0] sync_b_r;
  // ==========================================================
  // two-flop synchronisers, first stage read only by the second
  assign raw = {int_three_in, int_zero_in, ext_trig_in,
                input_two_in, input_one_in};
  genvar gi;
  generate
    for (gi = 0; gi < NLINES; gi++) begin : g_sync
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          sync_a_r[gi] <= 1'b0;
          sync_b_r[gi] <= 1'b0;
        end else if (ce_in) begin
          sync_a_r[gi] <= raw[gi];
          sync_b_r[gi] <= sync_a_r[gi];
        end
      end
    end
  endgenerate
  // levels, never single pulses, so gated mode sees a true level
  assign link.filtered_input_one        = sync_b_r[0];
  assign link.filtered_input_two        = sync_b_r[1];
  assign link.filtered_external_trigger = sync_b_r[2];
  assign link.internal_trigger_zero     = sync_b_r[3];
  assign link.internal_trigger_three    = sync_b_r[4];
  // ==========================================================
  // watch the timer's trigger output (same clock, no synchroniser)
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trig_level_out <= 1'b0;
      trig_rise_out  <= 1'b0;
    end else if (ce_in) begin
      trig_level_out <= link.trigger_output;
      trig_rise_out  <= link.trigger_output & ~trig_level_out;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// bench: timer control block facing its trigger peer over the link
// assumes package and interface compiled first; one 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import timer_ctl_pkg::*;
  logic sys_clk_in = 0, rst_n_in = 0, ce_in = 1, wr_in = 0, rd_in = 0;
  logic input_one_in = 0, input_two_in = 0, ext_trig_in = 0;
  logic int_zero_in = 0, int_three_in = 0, channel_one_match_in = 0;
  logic trig_level_out, trig_rise_out, update_event_out, update_irq_out;
  logic compare_allow_out, counter_running_out;
  logic [3:0] compare_ref_in = 4'h0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, channel_ctrl_in = 8'h00;
  logic [7:0] rdata_out, channel_ctrl_out;
  logic [15:0] counter_out;
  int n_errors = 0, n_tests = 0, n_rise = 0, n_irq = 0, r0;
  timer_link_if link();
  timer_control_slave u_timer_control_slave (.*);
  trigger_peer u_trigger_peer (.*);
  timer_link_props u_timer_link_props (.sys_clk_in, .rst_n_in,
    .trigger_output(link.trigger_output), .input_one_in,
    .filtered_input_one(link.filtered_input_one), .compare_ref_in,
    .channel_one_match_in, .update_event_out, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .trig_level_out, .trig_rise_out);
  // ==========================================================
  // clock, pulse tallies, watchdog (about fifteen times the run)
  always #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    n_rise += int'(trig_rise_out === 1'h1);
    n_irq += int'(update_irq_out === 1'h1);
  end
  initial begin
    #200000;
    n_errors++;
    conclude;
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // waits past the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge sys_clk_in);
    wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge sys_clk_in);
    rd_in <= 1'h0;
    #1 chk("rdata", 16'(rdata_out), 16'(e));
  endtask
  task automatic conclude;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence; each step builds on the counter left before
  initial begin
    cyc(10);
    rst_n_in <= 1'h1;
    for (int a = 0; a < 3; a++) rd(8'(a), 8'h00);
    wr(ADDR_CTL_TWO, 8'hff);
    rd(ADDR_CTL_TWO, 8'h75);
    wr(ADDR_SLV_CTL, 8'hff);
    rd(ADDR_SLV_CTL, 8'hf7);
    wr(ADDR_SLV_CTL, 8'h00);
    rd(8'h40, 8'h00);
    wr(ADDR_CTL_TWO, 8'h00);
    channel_ctrl_in <= 8'h5a;
    cyc(3);
    chk("chan", 16'(channel_ctrl_out), 16'h005a);
    wr(ADDR_CTL_TWO, 8'h01);
    channel_ctrl_in <= 8'ha5;
    cyc(3);
    chk("chan", 16'(channel_ctrl_out), 16'h005a);
    wr(ADDR_EVGEN, 8'h20);
    cyc(2);
    chk("chan", 16'(channel_ctrl_out), 16'h00a5);
    wr(ADDR_CTL_ONE, 8'h80);
    wr(ADDR_RLD_HI, 8'h00);
    wr(ADDR_RLD_LO, 8'h07);
    rd(ADDR_RLD_HI, 8'hff);
    r0 = n_irq;
    wr(ADDR_EVGEN, 8'h01);
    cyc(2);
    rd(ADDR_RLD_HI, 8'h00);
    chk("irq", 16'(n_irq), 16'(r0 + 1));
    wr(ADDR_CTL_ONE, 8'h84);
    wr(ADDR_EVGEN, 8'h01);
    cyc(2);
    chk("irq", 16'(n_irq), 16'(r0 + 1));
    wr(ADDR_CTL_ONE, 8'h82);
    wr(ADDR_RLD_LO, 8'h03);
    wr(ADDR_EVGEN, 8'h01);
    cyc(2);
    rd(ADDR_RLD_LO, 8'h07);
    chk("irq", 16'(n_irq), 16'(r0 + 1));
    wr(ADDR_CTL_ONE, 8'h80);
    wr(ADDR_RLD_LO, 8'h07);
    wr(ADDR_EVGEN, 8'h01);
    wr(ADDR_CTL_ONE, 8'h20);
    wr(ADDR_CTL_ONE, 8'h30);
    rd(ADDR_CTL_ONE, 8'h20);
    chk("allow", 16'(compare_allow_out), 16'h0000);
    // single pulse up then down, update events routed to the peer
    wr(ADDR_CTL_TWO, 8'h20);
    r0 = n_rise;
    wr(ADDR_CTL_ONE, 8'h09);
    cyc(12);
    rd(ADDR_CTL_ONE, 8'h08);
    rd(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CTL_ONE, 8'h19);
    cyc(4);
    rd(ADDR_CNT_LO, 8'h07);
    chk("rise", 16'(n_rise), 16'(r0 + 2));
    wr(ADDR_CTL_TWO, 8'h00);
    wr(ADDR_CTL_ONE, 8'h00);
    wr(ADDR_SLV_CTL, 8'h54);
    input_one_in <= 1'h1;
    cyc(6);
    rd(ADDR_CNT_LO, 8'h00);
    chk("rise", 16'(n_rise), 16'(r0 + 3));
    @(posedge sys_clk_in);
    input_one_in <= 1'h0;
    cyc(4);
    wr(ADDR_SLV_CTL, 8'h57);
    wr(ADDR_CTL_ONE, 8'h01);
    repeat (3) begin
      input_one_in <= 1'h1;
      repeat (4) @(posedge sys_clk_in);
      input_one_in <= 1'h0;
      repeat (4) @(posedge sys_clk_in);
    end
    rd(ADDR_CNT_LO, 8'h03);
    wr(ADDR_CTL_ONE, 8'h00);
    wr(ADDR_SLV_CTL, 8'h56);
    input_one_in <= 1'h1;
    cyc(6);
    rd(ADDR_CTL_ONE, 8'h01);
    chk("run", 16'(counter_running_out), 16'h0001);
    @(posedge sys_clk_in);
    input_one_in <= 1'h0;
    wr(ADDR_SLV_CTL, 8'h00);
    wr(ADDR_CTL_TWO, 8'h10);
    cyc(4);
    chk("lvl", 16'(trig_level_out), 16'h0001);
    wr(ADDR_CTL_ONE, 8'h00);
    cyc(4);
    chk("lvl", 16'(trig_level_out), 16'h0000);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTL_TWO, 8'h40 | 8'(m << 4));
      compare_ref_in <= 4'h1 << m;
      cyc(3);
      chk("lvl", 16'(trig_level_out), 16'h0001);
      @(posedge sys_clk_in);
      compare_ref_in <= ~(4'h1 << m);
      cyc(3);
      chk("lvl", 16'(trig_level_out), 16'h0000);
    end
    wr(ADDR_CTL_TWO, 8'h30);
    r0 = n_rise;
    channel_one_match_in <= 1'h1;
    @(posedge sys_clk_in);
    channel_one_match_in <= 1'h0;
    cyc(4);
    chk("rise", 16'(n_rise), 16'(r0 + 1));
    // gated counting: four cycles of high trigger give four ticks
    wr(ADDR_EVGEN, 8'h01);
    wr(ADDR_SLV_CTL, 8'h55);
    wr(ADDR_CTL_ONE, 8'h01);
    input_one_in <= 1'h1;
    repeat (4) @(posedge sys_clk_in);
    input_one_in <= 1'h0;
    cyc(4);
    rd(ADDR_CNT_LO, 8'h04);
    // encoder on both inputs: up, up, then back down one step
    wr(ADDR_SLV_CTL, 8'h53);
    input_one_in <= 1'h1;
    repeat (4) @(posedge sys_clk_in);
    input_two_in <= 1'h1;
    repeat (4) @(posedge sys_clk_in);
    input_two_in <= 1'h0;
    cyc(4);
    rd(ADDR_CNT_LO, 8'h05);
    rd(ADDR_CTL_ONE, 8'h11);
    conclude;
  end
endmodule
`default_nettype wire

// ==== tb/timer_link_props.sv ====
// checker for the trigger link and the register port of the timer
// assumes one clock; fed by the link wires and a few port signals
`timescale 1ns/1ns
`default_nettype none
module timer_link_props
  import timer_ctl_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  input wire logic       trigger_output,
  input wire logic       filtered_input_one,
  input wire logic       input_one_in,
  input wire logic [3:0] compare_ref_in,
  input wire logic       channel_one_match_in,
  input wire logic       update_event_out,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       trig_level_out,
  input wire logic       trig_rise_out
);
  import timer_ctl_pkg::*;
  logic [2:0] mst_r;
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // shadow of master select, so routing is judged by its mode
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      mst_r <= 3'h0;
    else if (wr_in && addr_in == ADDR_CTL_TWO)
      mst_r <= wdata_in[6:4];
  end
  a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_slave_echo: assert property (wr_in && addr_in == ADDR_SLV_CTL ##2
    rd_in && addr_in == ADDR_SLV_CTL |=>
    rdata_out == ($past(wdata_in, 3) & SLV_CTL_MASK))
    else $error("slave control read back wrong");
  a_update_route: assert property (mst_r == MST_UPDATE
    && $stable(mst_r) |-> trigger_output == update_event_out)
    else $error("update not on trigger output");
  a_ref_route: assert property (mst_r[2] && $stable(mst_r) |->
    trigger_output == $past(compare_ref_in[mst_r[1:0]]))
    else $error("compare reference not routed");
  a_match_route: assert property (mst_r == MST_MATCH
    && $stable(mst_r) |-> trigger_output == $past(channel_one_match_in))
    else $error("match pulse not routed");
  a_peer_level: assert property (
    trig_level_out == $past(trigger_output))
    else $error("peer level lags wrongly");
  a_peer_rise: assert property (trig_rise_out ==
    ($past(trigger_output) && !$past(trigger_output, 2)))
    else $error("peer rise pulse wrong");
  a_sync_one: assert property (
    filtered_input_one == $past(input_one_in, 2))
    else $error("input one sync delay wrong");
endmodule
`default_nettype wire
